// ==== adc_clock_prescaler_and_interval_timer.sv ====
// Converter clock prescaler, interval timer and control registers
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_clk_defines.svh"
// How it works
// R1 - Converter clock drives seventeen stage divider timer
// R2 - Five bit down counter times high phase
// R3 - Low phase ends on complement match
// R4 - High lasts setting plus one, half extra
// R5 - Low lasts setting plus one, half less
// R6 - Half tick delays falling edge half cycle
// R7 - Software keeps system clock twice converter clock
// R8 - Software changes prescaler only with queues disabled
// R9 - Conversion takes sixteen plus sample ticks
// R10 - Timer held reset in untimed modes
// R11 - Interval single mode without go holds reset
// R12 - Resets and stop hold timer reset
// R13 - Rollover or timer mode change pulses reset
// R14 - Stop clears queue two control register
// R15 - Honoured freeze resets timer after conversion
// R16 - Freeze before first trigger acts immediately
// R17 - Three control registers, one status register
// R18 - Single scan go bits read zero
// R19 - Prescaler register holds phases and mux enable
// R20 - Queue registers hold mode, interrupt enables
// R21 - Interval selectable from two-seven to two-seventeen
// R22 - Expiry triggers queue two and reloads
// R23 - Trigger is one cycle stage rollover pulse
module adc_clock_prescaler_and_interval_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // System control
   input wire logic masterReset,
   input wire logic lowPowerStop,
   input wire logic freezeLine,
   // Queue sequencer
   input wire logic convStart,
   input wire logic [1:0] sampleTimeSelect,
   input wire logic queueOneScanDone,
   input wire logic queueTwoScanDone,
   output adc_clk_pkg::queue_ctrl_s queueOneCtrl,
   output adc_clk_pkg::queue_ctrl_s queueTwoCtrl,
   output logic extMuxEnable,
   output logic conversionBusy,
   output logic conversionDone,
   // Clock and trigger
   output logic converterClock,
   output logic qclkTick,
   output logic timerTrigger
);

   // =======================================
   // Reset release
   logic [1:0] rstSync_q;
   logic rstN;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end

   assign rstN = rstSync_q[1];

   // =======================================
   // Helpers
   function automatic logic [31:0] mergeBe(
      input logic [31:0] old,
      input logic [31:0] wdata,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return r;
   endfunction : mergeBe

   function automatic logic [31:0] pscWord(input adc_clk_pkg::prescaler_cfg_s p);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`PSC_LOW_LSB +: 3] = p.lowPhase;
      w[`PSC_HALF_BIT] = p.halfTick;
      w[`PSC_HIGH_LSB +: 5] = p.highPhase;
      w[`PSC_EXTMUX_BIT] = p.extMuxEn;
      w[`PSC_FREEZE_BIT] = p.freezeHonor;
      return w;
   endfunction : pscWord

   function automatic logic [31:0] queueWord(input adc_clk_pkg::queue_ctrl_s q);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`QC_SEL_LSB +: 4] = q.intervalSel;
      w[`QC_MODE_LSB +: 4] = q.mode;
      w[`QC_GO_BIT] = q.scanGo;
      w[`QC_PAUSE_IE_BIT] = q.pauseIntEn;
      w[`QC_DONE_IE_BIT] = q.doneIntEn;
      return w;
   endfunction : queueWord

   function automatic adc_clk_pkg::queue_ctrl_s queueFields(input logic [31:0] w);
      adc_clk_pkg::queue_ctrl_s q;
      q.intervalSel = w[`QC_SEL_LSB +: 4];
      q.mode = adc_clk_pkg::queue_mode_e'(w[`QC_MODE_LSB +: 4]);
      q.scanGo = w[`QC_GO_BIT];
      q.pauseIntEn = w[`QC_PAUSE_IE_BIT];
      q.doneIntEn = w[`QC_DONE_IE_BIT];
      return q;
   endfunction : queueFields

   function automatic logic isTimerMode(input adc_clk_pkg::queue_mode_e m);
      return (m == adc_clk_pkg::MODE_INTERVAL_SINGLE) ||
             (m == adc_clk_pkg::MODE_PERIODIC_CONT);
   endfunction : isTimerMode

   // =======================================
   // Declarations
   adc_clk_pkg::bus_state_e bus_q, bus_d;
   logic [31:0] readData_q, readData_d;
   adc_clk_pkg::prescaler_cfg_s psc_q, psc_d;
   adc_clk_pkg::queue_ctrl_s q1_q, q1_d;
   adc_clk_pkg::queue_ctrl_s q2_q, q2_d;
   adc_clk_pkg::queue_mode_e prevMode_q, prevMode_d;
   logic triggerSeen_q, triggerSeen_d;
   logic freezeHold_q, freezeHold_d;
   adc_clk_pkg::conv_state_e conv_q, conv_d;
   logic [5:0] convLeft_q, convLeft_d;
   logic convDone_q, convDone_d;
   logic commit;
   logic [31:0] statusWord;
   logic [31:0] wordNow;
   logic [16:0] timerCount;
   logic timerMode;
   logic timerHold;
   logic timerPulse;
   logic freezeReq;

   // =======================================
   // Bus slave
   // Every access waits one cycle; read data is registered at the first edge
   always_comb begin
      bus_d = bus_q;
      readData_d = readData_q;
      case (bus_q)
         adc_clk_pkg::BUS_IDLE: begin
            if (avsRead || avsWrite) begin
               bus_d = adc_clk_pkg::BUS_ACK;
            end
            if (avsRead) begin
               case (avsAddress)
                  `OFS_PRESCALER: readData_d = pscWord(psc_q); // R17 R19
                  `OFS_QUEUE_ONE: readData_d = queueWord(q1_q) & ~(32'h1 << `QC_GO_BIT); // R18
                  `OFS_QUEUE_TWO: readData_d = queueWord(q2_q) & ~(32'h1 << `QC_GO_BIT); // R18
                  `OFS_STATUS: readData_d = statusWord;
                  default: readData_d = 32'h0000_0000; // R17
               endcase
            end
         end
         adc_clk_pkg::BUS_ACK: begin
            bus_d = adc_clk_pkg::BUS_IDLE;
         end
         default: begin
            bus_d = adc_clk_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         bus_q <= adc_clk_pkg::BUS_IDLE;
         readData_q <= 32'h0000_0000;
      end else begin
         bus_q <= bus_d;
         readData_q <= readData_d;
      end
   end

   assign avsWaitRequest = (avsRead || avsWrite) && (bus_q != adc_clk_pkg::BUS_ACK);
   assign avsReadData = readData_q;
   assign commit = avsWrite && (bus_q == adc_clk_pkg::BUS_ACK);

   // =======================================
   // Control registers
   // Prescaler writes are always taken; mid-conversion changes are unsafe
   always_comb begin
      psc_d = psc_q;
      q1_d = q1_q;
      q2_d = q2_q;
      wordNow = 32'h0000_0000;
      if (queueOneScanDone) begin
         q1_d.scanGo = 1'b0;
      end
      if (queueTwoScanDone) begin
         q2_d.scanGo = 1'b0;
      end
      if (commit) begin
         case (avsAddress)
            `OFS_PRESCALER: begin
               wordNow = mergeBe(pscWord(psc_q), avsWriteData, avsByteEnable); // R8
               psc_d.lowPhase = wordNow[`PSC_LOW_LSB +: 3]; // R19
               psc_d.halfTick = wordNow[`PSC_HALF_BIT];
               psc_d.highPhase = wordNow[`PSC_HIGH_LSB +: 5];
               psc_d.extMuxEn = wordNow[`PSC_EXTMUX_BIT];
               psc_d.freezeHonor = wordNow[`PSC_FREEZE_BIT];
            end
            `OFS_QUEUE_ONE: begin
               wordNow = mergeBe(queueWord(q1_q), avsWriteData, avsByteEnable);
               q1_d = queueFields(wordNow); // R20 R18
               q1_d.intervalSel = 4'h0;
            end
            `OFS_QUEUE_TWO: begin
               wordNow = mergeBe(queueWord(q2_q), avsWriteData, avsByteEnable);
               q2_d = queueFields(wordNow); // R20 R18 R21
            end
            default: begin
               wordNow = 32'h0000_0000; // R17
            end
         endcase
      end
      if (lowPowerStop) begin
         q2_d = '0; // R14
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         psc_q <= '{freezeHonor: 1'b0, extMuxEn: 1'b0, highPhase: `PSC_HIGH_RESET,
                    halfTick: 1'b0, lowPhase: `PSC_LOW_RESET};
         q1_q <= '0;
         q2_q <= '0;
      end else begin
         psc_q <= psc_d;
         q1_q <= q1_d;
         q2_q <= q2_d;
      end
   end

   assign queueOneCtrl = q1_q;
   assign queueTwoCtrl = q2_q;
   assign extMuxEnable = psc_q.extMuxEn;

   // =======================================
   // Converter clock
   converter_clock_gen u_clock (
      .clk(clk),
      .rst_n(rstN),
      .run(!lowPowerStop),
      .cfg(psc_q),
      .converterClock(converterClock),
      .qclkTick(qclkTick)
   );

   // =======================================
   // Conversion timing
   always_comb begin
      conv_d = conv_q;
      convLeft_d = convLeft_q;
      convDone_d = 1'b0;
      case (conv_q)
         adc_clk_pkg::CONV_IDLE: begin
            if (convStart && !lowPowerStop) begin
               conv_d = adc_clk_pkg::CONV_RUN;
               convLeft_d = 6'(`CONV_BASE_TICKS + (6'h02 << sampleTimeSelect)); // R9
            end
         end
         adc_clk_pkg::CONV_RUN: begin
            if (lowPowerStop) begin
               conv_d = adc_clk_pkg::CONV_IDLE;
            end else if (qclkTick) begin
               convLeft_d = 6'(convLeft_q - 6'h01);
               if (convLeft_q == 6'h01) begin
                  conv_d = adc_clk_pkg::CONV_IDLE; // R9
                  convDone_d = 1'b1;
               end
            end
         end
         default: begin
            conv_d = adc_clk_pkg::CONV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         conv_q <= adc_clk_pkg::CONV_IDLE;
         convLeft_q <= 6'h00;
         convDone_q <= 1'b0;
      end else begin
         conv_q <= conv_d;
         convLeft_q <= convLeft_d;
         convDone_q <= convDone_d;
      end
   end

   assign conversionBusy = (conv_q == adc_clk_pkg::CONV_RUN);
   assign conversionDone = convDone_q;

   // =======================================
   // Timer control
   assign timerMode = isTimerMode(q2_q.mode);
   assign freezeReq = psc_q.freezeHonor && freezeLine && timerMode;
   assign timerHold = !timerMode || // R10
                      ((q2_q.mode == adc_clk_pkg::MODE_INTERVAL_SINGLE) && !q2_q.scanGo) || // R11
                      masterReset || lowPowerStop || // R12
                      freezeHold_q; // R15 R16
   assign timerPulse = timerMode && isTimerMode(prevMode_q) &&
                       (q2_q.mode != prevMode_q); // R13

   always_comb begin
      prevMode_d = q2_q.mode;
      triggerSeen_d = triggerSeen_q;
      // Freeze waits for the running conversion unless nothing was triggered yet
      freezeHold_d = freezeReq &&
                     (freezeHold_q || !triggerSeen_q || !conversionBusy); // R15 R16
      if (timerHold) begin
         triggerSeen_d = 1'b0;
      end else if (timerTrigger) begin
         triggerSeen_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         prevMode_q <= adc_clk_pkg::MODE_DISABLED;
         triggerSeen_q <= 1'b0;
         freezeHold_q <= 1'b0;
      end else begin
         prevMode_q <= prevMode_d;
         triggerSeen_q <= triggerSeen_d;
         freezeHold_q <= freezeHold_d;
      end
   end

   interval_timer u_timer (
      .clk(clk),
      .rst_n(rstN),
      .holdReset(timerHold),
      .pulseReset(timerPulse),
      .tick(qclkTick),
      .intervalSel(q2_q.intervalSel),
      .count(timerCount),
      .trigger(timerTrigger)
   );

   // =======================================
   // Status
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[0] = converterClock;
      statusWord[1] = timerHold;
      statusWord[2] = freezeHold_q;
      statusWord[3] = conversionBusy;
      statusWord[4] = triggerSeen_q;
      statusWord[`ST_COUNT_LSB +: 17] = timerCount;
   end

endmodule : adc_clock_prescaler_and_interval_timer

// ==== adc_clk_defines.svh ====
// Offsets, field positions, reset values and counts for the converter clock block
`ifndef ADC_CLK_DEFINES_SVH
`define ADC_CLK_DEFINES_SVH
// =======================================
// Register byte offsets
`define OFS_PRESCALER 4'h0
`define OFS_QUEUE_ONE 4'h4
`define OFS_QUEUE_TWO 4'h8
`define OFS_STATUS 4'hc
// =======================================
// Prescaler control fields
`define PSC_LOW_LSB 0
`define PSC_HALF_BIT 3
`define PSC_HIGH_LSB 4
`define PSC_EXTMUX_BIT 15
`define PSC_FREEZE_BIT 31
`define PSC_HIGH_RESET 5'h07
`define PSC_LOW_RESET 3'h7
// =======================================
// Queue control fields
`define QC_SEL_LSB 0
`define QC_MODE_LSB 8
`define QC_GO_BIT 13
`define QC_PAUSE_IE_BIT 14
`define QC_DONE_IE_BIT 15
// =======================================
// Status fields
`define ST_COUNT_LSB 8
// =======================================
// Timing counts
`define CONV_BASE_TICKS 6'h10
`define TMR_MIN_EXP 5'h07
`define TMR_MAX_SEL 4'ha
`endif

// ==== adc_clk_pkg.sv ====
// Types shared by the converter clock block
package adc_clk_pkg;
   typedef enum logic [3:0] {
      MODE_DISABLED = 4'h0,
      MODE_SW_SINGLE = 4'h1,
      MODE_EXT_RISE_SINGLE = 4'h2,
      MODE_EXT_FALL_SINGLE = 4'h3,
      MODE_INTERVAL_SINGLE = 4'h4,
      MODE_SW_CONT = 4'h5,
      MODE_EXT_RISE_CONT = 4'h6,
      MODE_EXT_FALL_CONT = 4'h7,
      MODE_PERIODIC_CONT = 4'h8
   } queue_mode_e;
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_state_e;
   typedef enum logic {CONV_IDLE = 1'b0, CONV_RUN = 1'b1} conv_state_e;
   typedef struct packed {
      logic freezeHonor;
      logic extMuxEn;
      logic [4:0] highPhase;
      logic halfTick;
      logic [2:0] lowPhase;
   } prescaler_cfg_s;
   typedef struct packed {
      logic doneIntEn;
      logic pauseIntEn;
      logic scanGo;
      queue_mode_e mode;
      logic [3:0] intervalSel;
   } queue_ctrl_s;
endpackage : adc_clk_pkg

// ==== converter_clock_gen.sv ====
// Programmable converter clock prescaler
`timescale 1ns/100ps
module converter_clock_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input adc_clk_pkg::prescaler_cfg_s cfg,
   // Clock out
   output logic converterClock,
   output logic qclkTick
);
   logic high_q, high_d;
   logic [4:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic highNeg_q;

   // =======================================
   // Phase counter
   always_comb begin
      high_d = high_q;
      cnt_d = 5'(cnt_q - 5'h01); // R2
      tick_d = 1'b0;
      if (!run) begin
         high_d = 1'b0;
         cnt_d = 5'h1f;
      end else if (high_q) begin
         if (cnt_q == 5'h00) begin
            high_d = 1'b0; // R2 R4
         end
      end else if (cnt_q[2:0] == ~cfg.lowPhase) begin
         high_d = 1'b1; // R3 R5
         cnt_d = cfg.highPhase; // R2
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_q <= 1'b0;
         cnt_q <= 5'h1f;
         tick_q <= 1'b0;
      end else begin
         high_q <= high_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   // =======================================
   // Half tick stretch
   // Falling edge copy delays only the fall; the rise leads it
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         highNeg_q <= 1'b0;
      end else begin
         highNeg_q <= high_q;
      end
   end

   assign converterClock = high_q | (cfg.halfTick & highNeg_q); // R6 R4 R5
   assign qclkTick = tick_q;
endmodule : converter_clock_gen

// ==== interval_timer.sv ====
// Seventeen stage periodic and interval timer
`timescale 1ns/100ps
`include "adc_clk_defines.svh"
module interval_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic holdReset,
   input wire logic pulseReset,
   input wire logic tick,
   input wire logic [3:0] intervalSel,
   // Status
   output logic [16:0] count,
   output logic trigger
);
   logic [16:0] count_q, count_d;
   logic trig_q, trig_d;

   // Top stage of the selected interval is all ones
   function automatic logic stageFull(input logic [16:0] c, input logic [3:0] sel);
      logic [3:0] s;
      logic [16:0] mask;
      s = (sel > `TMR_MAX_SEL) ? `TMR_MAX_SEL : sel;
      mask = 17'((17'h00001 << (`TMR_MIN_EXP + 5'(s))) - 17'h00001);
      return (c & mask) == mask;
   endfunction : stageFull

   // =======================================
   // Divider
   always_comb begin
      count_d = count_q;
      trig_d = 1'b0;
      if (holdReset || pulseReset) begin
         count_d = 17'h00000; // R10 R11 R12 R13
      end else if (tick) begin
         if (stageFull(count_q, intervalSel)) begin
            count_d = 17'h00000; // R13 R22
            trig_d = 1'b1; // R23
         end else begin
            count_d = 17'(count_q + 17'h00001); // R1 R21
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 17'h00000;
         trig_q <= 1'b0;
      end else begin
         count_q <= count_d;
         trig_q <= trig_d;
      end
   end

   assign count = count_q;
   assign trigger = trig_q;
endmodule : interval_timer

// ==== adc_clk_chk.sv ====
// Port checks for the converter clock block
`timescale 1ns/100ps
// ======================================
// Checker
module adc_clk_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus and system control
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic avsWaitRequest,
   input wire logic masterReset,
   input wire logic lowPowerStop,
   // Queue side
   input wire logic conversionBusy,
   input wire logic conversionDone,
   input adc_clk_pkg::queue_ctrl_s queueTwoCtrl,
   // Clock and trigger
   input wire logic converterClock,
   input wire logic qclkTick,
   input wire logic timerTrigger
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic timerMode = queueTwoCtrl.mode == adc_clk_pkg::MODE_INTERVAL_SINGLE ||
      queueTwoCtrl.mode == adc_clk_pkg::MODE_PERIODIC_CONT;
   wire logic idleGo = queueTwoCtrl.mode == adc_clk_pkg::MODE_INTERVAL_SINGLE &&
      !queueTwoCtrl.scanGo;
   // Two or three cycles of margin cover a trigger already in flight
   property p_tick; qclkTick |-> converterClock && !$past(converterClock); endproperty
   property p_tick1; qclkTick |=> !qclkTick; endproperty
   property p_trig_tick; timerTrigger |-> $past(qclkTick); endproperty
   property p_trig1; timerTrigger |=> !timerTrigger; endproperty
   property p_untimed; !timerMode [*3] |-> !timerTrigger; endproperty
   property p_nogo; idleGo [*3] |-> !timerTrigger; endproperty
   property p_master; masterReset [*2] |-> !timerTrigger; endproperty
   property p_stop; lowPowerStop [*3] |-> !converterClock && queueTwoCtrl == '0; endproperty
   property p_done; conversionDone |-> $past(conversionBusy); endproperty
   property p_wait; $rose(avsRead || avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest; endproperty
   a_tick: assert property (p_tick) else $error("tick off high start");
   a_tick1: assert property (p_tick1) else $error("tick too long");
   a_trig_tick: assert property (p_trig_tick) else $error("trigger without tick");
   a_trig1: assert property (p_trig1) else $error("trigger too long");
   a_untimed: assert property (p_untimed) else $error("trigger in untimed mode");
   a_nogo: assert property (p_nogo) else $error("trigger without go");
   a_master: assert property (p_master) else $error("trigger in master reset");
   a_stop: assert property (p_stop) else $error("stop not honoured");
   a_done: assert property (p_done) else $error("done while idle");
   a_wait: assert property (p_wait) else $error("wait cycle wrong");
   c_trig: cover property (timerTrigger);
   c_done: cover property (conversionDone);
   c_stop: cover property (lowPowerStop ##1 !lowPowerStop);
endmodule : adc_clk_chk

bind adc_clock_prescaler_and_interval_timer adc_clk_chk u_adc_clk_chk (.*);

// ==== queue_seq_model.sv ====
// Queue sequencer stand-in facing the converter clock block
`timescale 1ns/100ps
// ======================================
// Sequencer model
module queue_seq_model (
   // Clock
   input wire logic clk,
   // Bench control
   input wire logic kick,
   input wire logic endScan,
   input wire logic [1:0] sel,
   // Block side
   input wire logic timerTrigger,
   input wire logic conversionDone,
   output logic convStart,
   output logic [1:0] sampleTimeSelect,
   output logic queueTwoScanDone
);
   // One process drives every output; the bench holds kick low from time zero
   always @(posedge clk) begin
      convStart <= kick | timerTrigger;
      sampleTimeSelect <= sel;
      queueTwoScanDone <= conversionDone & endScan;
   end
endmodule : queue_seq_model

// ==== tb.sv ====
// Self-checking bench for the converter clock block
`timescale 1ns/100ps
`include "adc_clk_defines.svh"
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
   end \
end
// ======================================
// Bench
module tb;
   logic clk, reset_n, avsRead, avsWrite, masterReset, lowPowerStop, freezeLine;
   logic [3:0] avsAddress;
   logic [3:0] avsByteEnable = 4'hf;
   logic queueOneScanDone = 1'b0;
   logic [31:0] avsWriteData, avsReadData, rdat;
   logic avsWaitRequest, convStart, queueTwoScanDone, kick, endScan, extMuxEnable;
   logic conversionBusy, conversionDone, converterClock, qclkTick, timerTrigger;
   logic [1:0] sampleTimeSelect, sel;
   adc_clk_pkg::queue_ctrl_s queueOneCtrl, queueTwoCtrl;
   int fails, total_checks, n;
   int hv[4] = '{3, 3, 31, 0};
   int lv[4] = '{3, 3, 7, 0};
   int av[4] = '{0, 1, 1, 0};
   realtime t0, t1, t2;
   adc_clock_prescaler_and_interval_timer u_adc_clock_prescaler_and_interval_timer (.*);
   queue_seq_model u_queue_seq_model (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #1000000;
      fails++;
      end_sim();
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      logic w;
      int c;
      c = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      do begin
         @(negedge clk);
         w = avsWaitRequest;
         rdat = avsReadData;
         @(posedge clk);
         c++;
      end while (w !== 1'b0 && c < 50);
      if (w !== 1'b0) fails++;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus
   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(nm, e, rdat)
   endtask : rd
   task automatic trigs(input int cyc, input int e);
      n = 0;
      repeat (cyc) begin
         @(negedge clk);
         n += int'(timerTrigger === 1'b1);
      end
      `CHK("trigs", e, n)
   endtask : trigs
   // Ticks from one trigger up to the next
   task automatic gap();
      int c;
      c = 0;
      n = 0;
      @(negedge clk);
      while (timerTrigger !== 1'b1 && c++ < 9000) @(negedge clk);
      @(negedge clk);
      while (timerTrigger !== 1'b1 && c++ < 9000) begin
         n += int'(qclkTick === 1'b1);
         @(negedge clk);
      end
   endtask : gap
   initial begin
      {reset_n, avsRead, avsWrite, masterReset, lowPowerStop, freezeLine, kick, endScan} = '0;
      avsAddress = 4'h0;
      avsWriteData = 32'h0;
      sel = 2'h0;
      fails = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      // ======================================
      // Registers
      rd("psc", `OFS_PRESCALER, 32'h00000077);
      rd("q2", `OFS_QUEUE_TWO, 32'h0);
      bus(1'b1, `OFS_PRESCALER, 32'hffffffff);
      rd("psc", `OFS_PRESCALER, 32'h800081ff);
      `CHK("mux", 1'b1, extMuxEnable)
      bus(1'b1, `OFS_QUEUE_ONE, 32'hffffe10f);
      rd("q1", `OFS_QUEUE_ONE, 32'h0000c100);
      `CHK("go1", 1'b1, queueOneCtrl.scanGo)
      queueOneScanDone <= 1'b1;
      @(posedge clk);
      queueOneScanDone <= 1'b0;
      @(negedge clk);
      `CHK("go1clr", 1'b0, queueOneCtrl.scanGo)
      bus(1'b1, `OFS_QUEUE_ONE, 32'h0);
      bus(1'b1, 4'h2, 32'hffffffff);
      rd("hole", 4'h2, 32'h0);
      // ======================================
      // Clock phases, all settings keep the system clock twice as fast
      foreach (hv[i]) begin
         bus(1'b1, `OFS_PRESCALER, {23'h0, hv[i][4:0], av[i][0], lv[i][2:0]});
         @(posedge converterClock);
         @(posedge converterClock);
         t0 = $realtime;
         @(negedge converterClock);
         t1 = $realtime;
         @(posedge converterClock);
         t2 = $realtime;
         `CHK("high", 200 * (1 + hv[i]) + 100 * av[i], int'(10 * (t1 - t0)))
         `CHK("low", 200 * (1 + lv[i]) - 100 * av[i], int'(10 * (t2 - t1)))
      end
      // ======================================
      // Conversion length per sample time
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         sel <= s[1:0];
         kick <= 1'b1;
         @(posedge clk);
         kick <= 1'b0;
         n = 0;
         do begin
            @(negedge clk);
            n += int'(conversionBusy === 1'b1 && qclkTick === 1'b1);
         end while (conversionDone !== 1'b1 && n < 99);
         `CHK("conv", 16 + (2 << s), n)
      end
      // ======================================
      // Timer periods and restarts
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, `OFS_QUEUE_TWO, 32'h800 | s);
         gap();
         `CHK("period", 128 << s, n)
      end
      bus(1'b1, `OFS_QUEUE_TWO, 32'h800);
      gap();
      repeat (100) @(posedge clk);
      bus(1'b1, `OFS_QUEUE_TWO, 32'h2400);
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK("restart", 1'b1, rdat[24:8] < 17'h8)
      endScan <= 1'b1;
      trigs(400, 1);
      `CHK("go2", 1'b0, queueTwoCtrl.scanGo)
      trigs(600, 0);
      rd("q2", `OFS_QUEUE_TWO, 32'h0400);
      endScan <= 1'b0;
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0500);
      trigs(600, 0);
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0800);
      masterReset <= 1'b1;
      trigs(600, 0);
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK("mhold", 18'h1, {rdat[24:8], rdat[1]})
      masterReset <= 1'b0;
      // ======================================
      // Low-power stop
      lowPowerStop <= 1'b1;
      trigs(300, 0);
      rd("q2", `OFS_QUEUE_TWO, 32'h0);
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0800);
      rd("q2", `OFS_QUEUE_TWO, 32'h0);
      lowPowerStop <= 1'b0;
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0800);
      trigs(600, 2);
      // ======================================
      // Freeze before any trigger
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0);
      bus(1'b1, `OFS_PRESCALER, 32'h80000000);
      bus(1'b1, `OFS_QUEUE_TWO, 32'h0800);
      repeat (50) @(posedge clk);
      freezeLine <= 1'b1;
      trigs(300, 0);
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK("fhold", 18'h1, {rdat[24:8], rdat[2]})
      freezeLine <= 1'b0;
      // Hold drops one edge after release; count only ticks the timer sees
      @(posedge clk);
      n = 0;
      while (timerTrigger !== 1'b1 && n < 999) begin
         @(negedge clk);
         n += int'(qclkTick === 1'b1);
      end
      `CHK("frz", 128, n)
      end_sim();
   end
endmodule : tb
